// >>> spb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module spb_host_model (
  input  wire logic [7:0] i_dev_data,  // device drive values
  input  wire logic [7:0] i_dev_oe_n,  // device enables, low drives
  input  wire logic       i_sys_clk,   // system clock
  output wire logic [7:0] o_bus,       // resolved data pin levels
  output var  logic       o_cs_n,      // chip select, active low
  output var  logic       o_wr_n,      // write strobe, active low
  output var  logic       o_rd_n       // read strobe, active low
);
  logic [7:0] drv;

  // no pull-ups: a pin the device leaves undriven shows the host byte, which is inverted after every access
  assign o_bus = (~i_dev_oe_n & i_dev_data) | (i_dev_oe_n & drv);

  initial begin
    drv = 8'h00;
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one strobed access; long tail so the device is idle before the next
  task automatic access(input logic sel, input logic is_wr, input logic [7:0] b,
                        output logic [7:0] q);
    @(posedge i_sys_clk);
    o_cs_n <= !sel;
    o_wr_n <= !is_wr;
    o_rd_n <= is_wr;
    if (is_wr)
      drv <= b;
    repeat (5) @(posedge i_sys_clk);
    q = o_bus;
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_rd_n <= 1'b1;
    // byte held past the synchroniser delay, then inverted
    repeat (4) @(posedge i_sys_clk);
    drv <= ~drv;
    repeat (10) @(posedge i_sys_clk);
  endtask
endmodule

`default_nettype wire

// >>> spb_port.v
`timescale 1ns/1ps
`default_nettype none
`include "spb_port_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module spb_port (
  input  wire       i_sys_clk,    // 25 MHz system clock
  input  wire       i_reset_n,    // async reset, active low
  input  wire [7:0] i_addr,       // register address
  input  wire [7:0] i_wdata,      // register write data
  input  wire       i_wr,         // register write strobe
  input  wire       i_rd,         // register read strobe
  output reg  [7:0] o_rdata,      // read data, cycle after i_rd
  input  wire [7:0] i_data_pin,   // data pin levels
  output reg  [7:0] o_data_pin,   // data pin drive values
  output reg  [7:0] o_data_oe_n,  // data pin enables, low drives
  input  wire       i_rd_n,       // read strobe pin, active low
  input  wire       i_wr_n,       // write strobe pin, active low
  input  wire       i_cs_n,       // chip select pin, active low
  output reg        o_irq         // level interrupt request
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WRITE = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_WAIT2 = 3'h3;
  localparam [2:0] ST_WAIT4 = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta;
  reg rst_n;

  // assert at once, release through two flops
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe synchronisers
  wire [2:0] strobe_sync;
  wire       rd_s;
  wire       wr_s;
  wire       cs_s;

  spb_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_async   ({i_cs_n, i_wr_n, i_rd_n}),
    .o_sync    (strobe_sync)
  );

  assign rd_s = strobe_sync[0];
  assign wr_s = strobe_sync[1];
  assign cs_s = strobe_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // register state
  reg [7:0] out_latch;
  reg [7:0] in_latch;
  reg [7:0] data_dir;
  reg       input_full_flag;
  reg       output_full_flag;
  reg       input_overflow_flag;
  reg       slave_port_enable;
  reg [2:0] strobe_dir;
  reg [2:0] analog_pin_cfg_bits;
  reg       slave_port_irq_flag;
  reg [7:0] irq_enables;
  reg [1:0] phase;
  reg [2:0] state;
  reg       was_write;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire strobes_ok;
  wire selected;
  wire ext_wr_low;
  wire ext_rd_low;
  wire cpu_wr_data;
  wire cpu_rd_data;
  wire end_event;

  // strobe pins count only as digital inputs
  assign strobes_ok = slave_port_enable
                    & (strobe_dir == `SPB_STROBE_DIGITAL)
                    & (analog_pin_cfg_bits == `SPB_STROBE_DIGITAL);
  assign selected   = strobes_ok & ~cs_s;
  assign ext_wr_low = selected & ~wr_s;
  assign ext_rd_low = selected & ~rd_s;

  assign cpu_wr_data = i_wr & (i_addr == `SPB_OFF_DATA);
  assign cpu_rd_data = i_rd & (i_addr == `SPB_OFF_DATA);

  // completion lands on phase four of the instruction clock
  assign end_event = (state == ST_WAIT4) & (phase == `SPB_PHASE_FOUR);

  ////////////////////////////////////////////////////////////////////////////
  // four-phase instruction clock, free running
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `SPB_PHASE_ONE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external access sequencer
  reg [2:0] next_state;
  reg       next_was_write;

  // write wins if a broken master lowers both strobes
  always @* begin
    next_state     = state;
    next_was_write = was_write;
    case (state)
      ST_IDLE: begin
        if (ext_wr_low) begin
          next_state = ST_WRITE;
        end else if (ext_rd_low) begin
          next_state = ST_READ;
        end
      end
      ST_WRITE: begin
        if (!ext_wr_low) begin
          next_state     = ST_WAIT2;
          next_was_write = 1'b1;
        end
      end
      ST_READ: begin
        if (!ext_rd_low) begin
          next_state     = ST_WAIT2;
          next_was_write = 1'b0;
        end
      end
      ST_WAIT2: begin
        if (phase == `SPB_PHASE_TWO) begin
          next_state = ST_WAIT4;
        end
      end
      ST_WAIT4: begin
        if (phase == `SPB_PHASE_FOUR) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // leaving slave mode abandons any access in flight
    if (!slave_port_enable) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      was_write <= 1'b0;
    end else begin
      state     <= next_state;
      was_write <= next_was_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data latches
  // incoming byte follows the pins until the write strobe rises
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_latch  <= `SPB_RST_LATCH;
      out_latch <= `SPB_RST_LATCH;
    end else begin
      if (state == ST_WRITE && ext_wr_low) begin
        in_latch <= i_data_pin;
      end
      if (cpu_wr_data) begin
        out_latch <= i_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status flags; hardware sets follow the software writes so they win, but the disable clear comes last and wins over them
  wire ctrl_wr;
  assign ctrl_wr = i_wr & (i_addr == `SPB_OFF_CTRL);

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_port_enable   <= 1'b0;
      strobe_dir          <= `SPB_RST_CTRL_DIR;
      input_full_flag     <= 1'b0;
      output_full_flag    <= 1'b0;
      input_overflow_flag <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        slave_port_enable   <= i_wdata[`SPB_CTRL_ENABLE];
        strobe_dir          <= i_wdata[2:0];
        input_overflow_flag <= i_wdata[`SPB_CTRL_OVERFLOW];
      end
      if (cpu_rd_data) begin
        input_full_flag <= 1'b0;
      end
      if (state == ST_IDLE && ext_rd_low && !ext_wr_low) begin
        output_full_flag <= 1'b0;
      end
      if (cpu_wr_data) begin
        output_full_flag <= 1'b1;
      end
      if (end_event && was_write) begin
        input_full_flag <= 1'b1;
      end
      // a second write against an unread byte
      if (state == ST_IDLE && ext_wr_low && input_full_flag) begin
        input_overflow_flag <= 1'b1;
      end
      // overflow is deliberately left alone here
      if (!slave_port_enable) begin
        input_full_flag  <= 1'b0;
        output_full_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // other software registers
  wire irq_clr;
  assign irq_clr = i_wr & (i_addr == `SPB_OFF_IRQ_CLEAR);

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_pin_cfg_bits <= `SPB_RST_ANALOG;
      irq_enables         <= `SPB_RST_IRQ_EN;
      data_dir            <= `SPB_RST_DATA_DIR;
    end else begin
      if (i_wr && i_addr == `SPB_OFF_ANALOG) begin
        analog_pin_cfg_bits <= i_wdata[2:0];
      end
      if (i_wr && i_addr == `SPB_OFF_IRQ_EN) begin
        irq_enables <= i_wdata;
      end
      if (i_wr && i_addr == `SPB_OFF_DATA_DIR) begin
        data_dir <= i_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt flag, write one to the clear register to drop it
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_port_irq_flag <= 1'b0;
    end else begin
      if (irq_clr && i_wdata[`SPB_IRQ_BIT]) begin
        slave_port_irq_flag <= 1'b0;
      end
      if (end_event) begin
        slave_port_irq_flag <= 1'b1;
      end
    end
  end

  // level request, only while enabled
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= slave_port_irq_flag & irq_enables[`SPB_IRQ_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin drive
  reg [7:0] next_pin;
  reg [7:0] next_oe_n;

  // slave mode: only a selected read drives, direction register unused
  always @* begin
    next_pin  = out_latch;
    next_oe_n = 8'hff;
    if (slave_port_enable) begin
      if (state == ST_READ && ext_rd_low) begin
        next_oe_n = 8'h00;
      end
    end else begin
      next_oe_n = data_dir;
    end
  end

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data_pin  <= `SPB_RST_LATCH;
      o_data_oe_n <= 8'hff;
    end else begin
      o_data_pin  <= next_pin;
      o_data_oe_n <= next_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  reg [7:0] next_rdata;

  // analog-selected strobe pins read as zero
  always @* begin
    next_rdata = 8'h00;
    case (i_addr)
      `SPB_OFF_DATA: begin
        next_rdata = slave_port_enable ? in_latch : i_data_pin;
      end
      `SPB_OFF_PINS: begin
        if (analog_pin_cfg_bits == `SPB_STROBE_DIGITAL) begin
          next_rdata = {5'h00, cs_s, wr_s, rd_s};
        end
      end
      `SPB_OFF_IRQ_FLAGS: begin
        next_rdata = {slave_port_irq_flag, 7'h00};
      end
      `SPB_OFF_DATA_DIR: begin
        next_rdata = data_dir;
      end
      `SPB_OFF_CTRL: begin
        next_rdata = {input_full_flag, output_full_flag, input_overflow_flag,
                      slave_port_enable, 1'b0, strobe_dir};
      end
      `SPB_OFF_IRQ_EN: begin
        next_rdata = irq_enables;
      end
      `SPB_OFF_ANALOG: begin
        next_rdata = {5'h00, analog_pin_cfg_bits};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // data holds for one cycle only, zero otherwise
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> spb_port_props.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module spb_port_props (
  input wire logic       i_sys_clk,    // system clock
  input wire logic       i_reset_n,    // reset, active low
  input wire logic [7:0] i_addr,       // register address
  input wire logic [7:0] i_wdata,      // register write data
  input wire logic       i_wr,         // register write strobe
  input wire logic       i_rd,         // register read strobe
  input wire logic [7:0] o_rdata,      // register read data
  input wire logic [7:0] i_data_pin,   // data pin levels
  input wire logic [7:0] o_data_pin,   // data pin drive values
  input wire logic [7:0] o_data_oe_n,  // data pin enables, low drives
  input wire logic       i_rd_n,       // read strobe pin
  input wire logic       i_wr_n,       // write strobe pin
  input wire logic       i_cs_n,       // chip select pin
  input wire logic       o_irq         // interrupt request
);
  logic [3:0] rcnt;
  logic [3:0] acnt;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  // cycles since a selected strobe; saturates so stale traffic never aliases
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rcnt <= 4'hf;
      acnt <= 4'hf;
    end else begin
      rcnt <= (!i_cs_n && !i_rd_n) ? 4'h0 : rcnt + {3'h0, rcnt != 4'hf};
      acnt <= (!i_cs_n && !(i_rd_n && i_wr_n)) ? 4'h0 : acnt + {3'h0, acnt != 4'hf};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sync delay plus release cycle bounds how long the pins may stay driven
  chk_oe_needs_rd: assert property (o_data_oe_n != 8'hff |-> rcnt <= 4'h6)
    else $error("data pins driven without a selected read");
  chk_oe_whole_byte: assert property (o_data_oe_n == 8'h00 || o_data_oe_n == 8'hff)
    else $error("data pin enables split");
  chk_drive_stable: assert property (o_data_oe_n == 8'h00 && $past(o_data_oe_n) == 8'h00
      && !$past(i_wr) |-> $stable(o_data_pin))
    else $error("driven byte changed during a read");
  chk_irq_early: assert property ($rose(i_cs_n) && !o_irq |-> !o_irq [*3])
    else $error("interrupt before the phase wait");
  chk_irq_cause: assert property ($rose(o_irq) |-> acnt <= 4'hc || $past(i_wr)
      || $past(i_wr, 2))
    else $error("interrupt with no completed access");
  chk_irq_clear: assert property (i_wr && i_addr == 8'h0d && i_wdata[7]
      && acnt > 4'hc |-> ##2 !o_irq)
    else $error("interrupt survived a clear");
  chk_irq_mask: assert property (i_wr && i_addr == 8'h8c && !i_wdata[7] |-> ##2 !o_irq)
    else $error("interrupt not masked");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  cover property (o_data_oe_n == 8'h00);
  cover property ($rose(o_irq));
  cover property (i_wr && i_addr == 8'h0d);
endmodule

bind spb_port spb_port_props spb_port_props_i (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_pin(i_data_pin),
  .o_data_pin(o_data_pin), .o_data_oe_n(o_data_oe_n), .i_rd_n(i_rd_n),
  .i_wr_n(i_wr_n), .i_cs_n(i_cs_n), .o_irq(o_irq));

`default_nettype wire

// >>> spb_port_regs.vh
`ifndef SPB_PORT_REGS_VH
`define SPB_PORT_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the plain register port
`define SPB_OFF_DATA      8'h08
`define SPB_OFF_PINS      8'h09
`define SPB_OFF_IRQ_FLAGS 8'h0c
`define SPB_OFF_IRQ_CLEAR 8'h0d
`define SPB_OFF_DATA_DIR  8'h88
`define SPB_OFF_CTRL      8'h89
`define SPB_OFF_IRQ_EN    8'h8c
`define SPB_OFF_ANALOG    8'h9f

////////////////////////////////////////////////////////////////////////////////
// slave_control_status field positions
`define SPB_CTRL_INPUT_FULL  7
`define SPB_CTRL_OUTPUT_FULL 6
`define SPB_CTRL_OVERFLOW    5
`define SPB_CTRL_ENABLE      4

// slave_port_irq_flag / slave_port_irq_enable position
`define SPB_IRQ_BIT 7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define SPB_RST_CTRL_DIR 3'h7
`define SPB_RST_IRQ_EN   8'h00
`define SPB_RST_ANALOG   3'h0
`define SPB_RST_DATA_DIR 8'hff
`define SPB_RST_LATCH    8'h00

// pin config value that makes the strobe pins digital inputs
`define SPB_STROBE_DIGITAL 3'h7

////////////////////////////////////////////////////////////////////////////////
// four-phase instruction clock, one phase per system clock
`define SPB_PHASE_ONE   2'h0
`define SPB_PHASE_TWO   2'h1
`define SPB_PHASE_THREE 2'h2
`define SPB_PHASE_FOUR  2'h3

`endif

// >>> spb_sync.v
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser, one pair per bit; idles high like the strobes
module spb_sync (
  input  wire       i_sys_clk,  // system clock
  input  wire       i_rst_n,    // synchronised reset, active low
  input  wire [2:0] i_async,    // asynchronous levels
  output wire [2:0] o_sync      // synchronised levels
);

  reg [2:0] meta;
  reg [2:0] stable;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_bit
      // first flop feeds only the second
      always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta[g]   <= 1'b1;
          stable[g] <= 1'b1;
        end else begin
          meta[g]   <= i_async[g];
          stable[g] <= meta[g];
        end
      end
    end
  endgenerate

  assign o_sync = stable;

endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} spb_row_t;
  logic       clk;
  logic       reset_n;
  logic       wr;
  logic       rd;
  logic       cs_n, wr_n, rd_n, irq;
  logic [7:0] addr, wdata, rdata, dout, oe_n, bus, q;
  int         err_count;
  int         cmp_count;
  // write-then-read rows; a zero w only reads
  spb_row_t   rows [13] = '{
    '{1'b0, 8'h89, 8'h00, 8'h07}, '{1'b0, 8'h0c, 8'h00, 8'h00}, '{1'b0, 8'h8c, 8'h00, 8'h00},
    '{1'b0, 8'h9f, 8'h00, 8'h00}, '{1'b0, 8'h88, 8'h00, 8'hff}, '{1'b0, 8'h09, 8'h00, 8'h00},
    '{1'b1, 8'h55, 8'h5a, 8'h00}, '{1'b1, 8'h0c, 8'h80, 8'h00}, '{1'b1, 8'h89, 8'hc7, 8'h07},
    '{1'b1, 8'h9f, 8'h07, 8'h07}, '{1'b0, 8'h09, 8'h00, 8'h07}, '{1'b1, 8'h8c, 8'h80, 8'h80},
    '{1'b1, 8'h89, 8'h17, 8'h17}};

  spb_port spb_port_i (
    .i_sys_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_data_pin(bus), .o_data_pin(dout), .o_data_oe_n(oe_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cs_n(cs_n), .o_irq(irq));

  spb_host_model spb_host_model_i (
    .i_dev_data(dout), .i_dev_oe_n(oe_n), .i_sys_clk(clk), .o_bus(bus),
    .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask

  task automatic ext(input logic sel, input logic is_wr, input logic [7:0] b);
    spb_host_model_i.access(sel, is_wr, b, q);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    {reset_n, wr, rd, addr, wdata, err_count, cmp_count} = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w)
        wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rows[i].e);
    end
    // outgoing byte fetched by the external master
    wr_reg(8'h08, 8'ha5);
    rd_reg(8'h89, 8'h57);
    ext(1'b1, 1'b0, 8'h00);
    check(q, 8'ha5);
    rd_reg(8'h89, 8'h17);
    rd_reg(8'h0c, 8'h80);
    check({7'h0, irq}, 8'h01);
    wr_reg(8'h0d, 8'h80);
    rd_reg(8'h0c, 8'h00);
    check({7'h0, irq}, 8'h00);
    // two writes with no read between them overflow the input latch
    ext(1'b1, 1'b1, 8'h3c);
    rd_reg(8'h89, 8'h97);
    rd_reg(8'h0c, 8'h80);
    ext(1'b1, 1'b1, 8'hc3);
    rd_reg(8'h89, 8'hb7);
    rd_reg(8'h08, 8'hc3);
    rd_reg(8'h89, 8'h37);
    wr_reg(8'h89, 8'h17);
    rd_reg(8'h89, 8'h17);
    // masking hides a flag that is still set
    wr_reg(8'h8c, 8'h00);
    rd_reg(8'h0c, 8'h80);
    check({7'h0, irq}, 8'h00);
    wr_reg(8'h0d, 8'h80);
    wr_reg(8'h8c, 8'h80);
    // strobe without chip select is ignored; direction register set to
    // all outputs must not steer the pins while slave mode is on
    wr_reg(8'h88, 8'h00);
    rd_reg(8'h88, 8'h00);
    ext(1'b0, 1'b0, 8'h00);
    check(oe_n, 8'hff);
    rd_reg(8'h0c, 8'h00);
    // back to inputs before leaving slave mode, else the pins would drive
    wr_reg(8'h88, 8'hff);
    // port disabled: full flags forced low, bus traffic ignored
    wr_reg(8'h08, 8'h11);
    wr_reg(8'h89, 8'h07);
    rd_reg(8'h89, 8'h07);
    ext(1'b1, 1'b1, 8'h5a);
    rd_reg(8'h0c, 8'h00);
    // strobe pins left analog keep the port deaf
    wr_reg(8'h89, 8'h17);
    wr_reg(8'h9f, 8'h00);
    ext(1'b1, 1'b1, 8'h66);
    rd_reg(8'h0c, 8'h00);
    // reset in mid-run
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h89, 8'h07);
    rd_reg(8'h8c, 8'h00);
    results();
  end
endmodule

`default_nettype wire
